// File: pkg/i2cr_pkg.sv
package i2cr_pkg;
  // register byte addresses inside block 000
  localparam logic [10:0] ADDR_CTL   = 11'h0C8;
  localparam logic [10:0] ADDR_CODE  = 11'h0CA;
  localparam logic [10:0] ADDR_PROT  = 11'h0E0;
  localparam logic [7:0]  MACRO_LO   = 8'h74;
  localparam logic [7:0]  MACRO_HI   = 8'h7B;
  localparam int          MACRO_BYTES = 8;
  localparam int          MEM_DEPTH  = 2048;
  // field positions
  localparam int          CTL_SRST_BIT  = 1;
  localparam int          CTL_LATCH_BIT = 2;
  localparam int          CODE_VAL_LSB  = 0;
  localparam int          CODE_SEL_LSB  = 4;
  localparam int          PROT_RD_LSB   = 0;
  localparam int          PROT_WR_LSB   = 2;
  // reset values
  localparam logic [7:0]  CTL_RST  = 8'h00;
  localparam logic [7:0]  CODE_RST = 8'h01;
  localparam logic [7:0]  PROT_RST = 8'h00;
  localparam logic [7:0]  LOCKED_RD_BYTE = 8'h00;
  // protection levels
  localparam logic [1:0]  PROT_OPEN  = 2'h0;
  localparam logic [1:0]  PROT_PART  = 2'h1;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam int          SYNC_W = 6;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_ACK  = 6'h04,
    ST_TX   = 6'h08,
    ST_MACK = 6'h10,
    ST_IGN  = 6'h20
  } i2cr_state_t;

  typedef enum logic [1:0] {
    K_CTRL = 2'h0,
    K_ADDR = 2'h1,
    K_DATA = 2'h2
  } i2cr_kind_t;
endpackage

// File: verilog/i2cr_sync.sv
`timescale 1ns/100ps
module i2cr_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_reg <= '1;
      q_reg    <= '1;
    end else if (ce) begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// File: verilog/i2cr_cfg_slave.sv
`timescale 1ns/100ps
// Functional notes
// - first byte after start holds the four-bit control code to compare.
// - each code bit comes from register or pin, picked per bit.
// - control code is 0001 after reset unless reconfigured.
// - block bits give address 10:8, word address byte gives 7:0.
// - last control bit one means read, zero means write.
// - acknowledge a control byte that matches our code.
// - byte write is control, address, one data byte, each acknowledged.
// - a data byte is stored when its acknowledge is driven.
// - with latch bit set, outputs hold during block 000 writes.
// - further data bytes go to the next higher address until stop.
// - pointer increments at first stop after a matching write control byte.
// - current read acks control, sends eight bits from pointer.
// - repeated start after address ends write but keeps the address.
// - random read returns data from the address just set.
// - master ack fetches the next byte; stop ends the read.
// - macrocell output bits are readable as registers.
// - four protection bits gate bus reads and writes.
// - serial reset bit reloads defaults and clears itself.
module i2cr_cfg_slave (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_pin_bit0,
  input  wire logic        addr_pin_bit1,
  input  wire logic        addr_pin_bit2,
  input  wire logic        addr_pin_bit3,
  input  wire logic [63:0] macro_out,
  output logic             out_hold,
  output logic             por_restart,
  output logic [3:0]       ctrl_code,
  output logic             busy
);
  i2cr_pkg::i2cr_state_t state_reg;
  i2cr_pkg::i2cr_kind_t  kind_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic [10:0] ptr_reg;
  logic        rw_reg;
  logic        wr_seen_reg;
  logic        first_reg;
  logic        blk0_wr_reg;
  logic        sda_oe_reg;
  logic        srst_reg;
  logic [7:0]  ctl_reg;
  logic [7:0]  code_reg;
  logic [7:0]  prot_reg;
  logic        scl_q_reg;
  logic        sda_q_reg;
  logic [7:0]  mem [0:i2cr_pkg::MEM_DEPTH-1];

  logic [5:0]  sync_q;
  wire         scl_s = sync_q[0];
  wire         sda_s = sync_q[1];
  wire  [3:0]  pin_s = sync_q[5:2];

  i2cr_sync #(
    .W (i2cr_pkg::SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .d        ({addr_pin_bit3, addr_pin_bit2, addr_pin_bit1,
                addr_pin_bit0, sda_in, scl_in}),
    .q        (sync_q)
  );

  // bus events, seen on the synchronised copies only
  wire scl_rise = scl_s & ~scl_q_reg;
  wire scl_fall = ~scl_s & scl_q_reg;
  wire start    = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  wire stop     = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
  wire quiet    = ce & ~start & ~stop;
  wire byte_end = (state_reg == i2cr_pkg::ST_RX) & scl_fall
                  & (bit_cnt_reg == i2cr_pkg::BITS_PER_BYTE);

  // per-bit choice of pin or register for the control code
  wire [3:0] code_sel = code_reg[i2cr_pkg::CODE_SEL_LSB +: 4];
  wire [3:0] code_val = code_reg[i2cr_pkg::CODE_VAL_LSB +: 4];
  wire [3:0] code_eff = (code_sel & pin_s)
                        | (~code_sel & code_val);
  wire       match    = shift_reg[7:4] == code_eff;

  // protection: partly locks block 000, full lock blocks all but writes to the protection byte
  wire [1:0] rd_lvl = prot_reg[i2cr_pkg::PROT_RD_LSB +: 2];
  wire [1:0] wr_lvl = prot_reg[i2cr_pkg::PROT_WR_LSB +: 2];
  wire [10:0] wr_addr = first_reg ? ptr_reg : ptr_reg + 11'h1;
  wire blk0_rd = ptr_reg[10:8] == 3'h0;
  wire blk0_wa = wr_addr[10:8] == 3'h0;
  wire rd_ok = (rd_lvl == i2cr_pkg::PROT_OPEN)
               | ((rd_lvl == i2cr_pkg::PROT_PART) & ~blk0_rd);
  wire wr_ok = (wr_lvl == i2cr_pkg::PROT_OPEN)
               | ((wr_lvl == i2cr_pkg::PROT_PART) & ~blk0_wa)
               | (wr_addr == i2cr_pkg::ADDR_PROT);

  wire is_macro_rd = blk0_rd & (ptr_reg[7:0] >= i2cr_pkg::MACRO_LO)
                     & (ptr_reg[7:0] <= i2cr_pkg::MACRO_HI);
  wire is_macro_wa = blk0_wa & (wr_addr[7:0] >= i2cr_pkg::MACRO_LO)
                     & (wr_addr[7:0] <= i2cr_pkg::MACRO_HI);
  wire [2:0] macro_idx = 3'(ptr_reg[7:0] - i2cr_pkg::MACRO_LO);
  wire [7:0] macro_byte = macro_out[{macro_idx, 3'h0} +: 8];

  wire [7:0] rd_raw =
    is_macro_rd                    ? macro_byte :
    (ptr_reg == i2cr_pkg::ADDR_CTL)  ? ctl_reg :
    (ptr_reg == i2cr_pkg::ADDR_CODE) ? code_reg :
    (ptr_reg == i2cr_pkg::ADDR_PROT) ? prot_reg : mem[ptr_reg];
  wire [7:0] rd_byte = rd_ok ? rd_raw : i2cr_pkg::LOCKED_RD_BYTE;

  // storage happens on the edge that starts our data acknowledge
  wire data_end = byte_end & (kind_reg == i2cr_pkg::K_DATA) & quiet;
  wire mem_we   = data_end & wr_ok & ~is_macro_wa;
  wire ack_rd   = (state_reg == i2cr_pkg::ST_ACK)
                  & (kind_reg == i2cr_pkg::K_CTRL) & rw_reg;
  wire load_tx  = scl_fall & quiet & (ack_rd
                  | ((state_reg == i2cr_pkg::ST_MACK)
                     & (bit_cnt_reg == 4'h1)));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else if (ce) begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[wr_addr] <= shift_reg;
    end
  end

  // special bytes live in flops so they can steer the block
  always_ff @(posedge core_clk) begin
    if (rst || (ce && srst_reg)) begin
      ctl_reg  <= i2cr_pkg::CTL_RST;
      code_reg <= i2cr_pkg::CODE_RST;
      prot_reg <= i2cr_pkg::PROT_RST;
      srst_reg <= 1'b0;
    end else if (ce && data_end && wr_ok) begin
      if (wr_addr == i2cr_pkg::ADDR_CTL) begin
        ctl_reg  <= shift_reg;
        srst_reg <= shift_reg[i2cr_pkg::CTL_SRST_BIT];
      end
      if (wr_addr == i2cr_pkg::ADDR_CODE) begin
        code_reg <= shift_reg;
      end
      if (wr_addr == i2cr_pkg::ADDR_PROT) begin
        prot_reg <= shift_reg;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg   <= i2cr_pkg::ST_IDLE;
      kind_reg    <= i2cr_pkg::K_CTRL;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      ptr_reg     <= 11'h000;
      rw_reg      <= 1'b0;
      wr_seen_reg <= 1'b0;
      first_reg   <= 1'b0;
      blk0_wr_reg <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else if (ce) begin
      if (start) begin
        // pointer survives a repeated start for the read half
        state_reg   <= i2cr_pkg::ST_RX;
        kind_reg    <= i2cr_pkg::K_CTRL;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg  <= 1'b0;
        blk0_wr_reg <= 1'b0;
      end else if (stop) begin
        state_reg   <= i2cr_pkg::ST_IDLE;
        sda_oe_reg  <= 1'b0;
        blk0_wr_reg <= 1'b0;
        wr_seen_reg <= 1'b0;
        if (wr_seen_reg) begin
          ptr_reg <= ptr_reg + 11'h1;
        end
      end else begin
        unique case (state_reg)
          i2cr_pkg::ST_IDLE, i2cr_pkg::ST_IGN: begin
          end
          i2cr_pkg::ST_RX: begin
            if (scl_rise && bit_cnt_reg < i2cr_pkg::BITS_PER_BYTE) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (byte_end) begin
              bit_cnt_reg <= 4'h0;
              state_reg   <= i2cr_pkg::ST_ACK;
              sda_oe_reg  <= 1'b1;
              unique case (kind_reg)
                i2cr_pkg::K_CTRL: begin
                  rw_reg <= shift_reg[0];
                  if (!match) begin
                    state_reg  <= i2cr_pkg::ST_IGN;
                    sda_oe_reg <= 1'b0;
                  end else if (!shift_reg[0]) begin
                    ptr_reg[10:8] <= shift_reg[3:1];
                    wr_seen_reg   <= 1'b1;
                    // latch enable frozen per command
                    blk0_wr_reg   <= ~|shift_reg[3:1]
                                     & ctl_reg[i2cr_pkg::CTL_LATCH_BIT];
                  end
                end
                i2cr_pkg::K_ADDR: begin
                  ptr_reg[7:0] <= shift_reg;
                  first_reg    <= 1'b1;
                end
                default: begin
                  ptr_reg   <= wr_addr;
                  first_reg <= 1'b0;
                end
              endcase
            end
          end
          i2cr_pkg::ST_ACK: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              if (ack_rd) begin
                // first data bit goes out with the ack release
                tx_reg      <= rd_byte;
                sda_oe_reg  <= ~rd_byte[7];
                bit_cnt_reg <= 4'h1;
                state_reg   <= i2cr_pkg::ST_TX;
              end else begin
                state_reg <= i2cr_pkg::ST_RX;
                // word address always follows a write control byte
                kind_reg  <= (kind_reg == i2cr_pkg::K_CTRL)
                             ? i2cr_pkg::K_ADDR
                             : i2cr_pkg::K_DATA;
              end
            end
          end
          i2cr_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == i2cr_pkg::BITS_PER_BYTE) begin
                sda_oe_reg  <= 1'b0;
                bit_cnt_reg <= 4'h0;
                state_reg   <= i2cr_pkg::ST_MACK;
              end else begin
                tx_reg      <= {tx_reg[6:0], 1'b1};
                sda_oe_reg  <= ~tx_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          i2cr_pkg::ST_MACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state_reg <= i2cr_pkg::ST_IGN;
              end else begin
                ptr_reg     <= ptr_reg + 11'h1;
                bit_cnt_reg <= 4'h1;
              end
            end else if (scl_fall && bit_cnt_reg == 4'h1) begin
              tx_reg     <= rd_byte;
              sda_oe_reg <= ~rd_byte[7];
              state_reg  <= i2cr_pkg::ST_TX;
            end
          end
        endcase
      end
    end
  end

  // open drain: the line is only ever pulled low
  assign sda_out     = 1'b0;
  assign sda_oe      = sda_oe_reg;
  assign out_hold    = blk0_wr_reg;
  assign por_restart = srst_reg;
  assign ctrl_code   = code_eff;
  assign busy        = state_reg != i2cr_pkg::ST_IDLE;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_ctrl_done;
    byte_end && kind_reg == i2cr_pkg::K_CTRL && quiet;
  endsequence
  sequence s_rd_ack_end;
    ack_rd && scl_fall && quiet;
  endsequence

  a_ctrl_ack_match: assert property (
    s_ctrl_done and match |=> sda_oe_reg && state_reg == i2cr_pkg::ST_ACK)
    else $error("matching control byte not acknowledged");
  a_mismatch_quiet: assert property (
    (s_ctrl_done and !match) |=> !sda_oe_reg [*3])
    else $error("mismatched code drove the data line");
  a_ign_released: assert property (
    state_reg == i2cr_pkg::ST_IGN |-> !sda_oe_reg)
    else $error("data line driven while ignoring");
  a_read_starts_tx: assert property (
    s_rd_ack_end |=> state_reg == i2cr_pkg::ST_TX
                     && tx_reg == $past(rd_byte))
    else $error("read did not start with pointer byte");
  a_commit_at_ack: assert property (
    mem_we |=> state_reg == i2cr_pkg::ST_ACK && sda_oe_reg)
    else $error("store not aligned with acknowledge");
  a_seq_write_next: assert property (
    mem_we && !first_reg |=> ptr_reg == $past(ptr_reg) + 11'h1)
    else $error("sequential write did not advance");
  a_stop_increment: assert property (
    stop && ce && wr_seen_reg |=> ptr_reg == $past(ptr_reg) + 11'h1)
    else $error("pointer not advanced at stop");
  a_addr_low_byte: assert property (
    byte_end && kind_reg == i2cr_pkg::K_ADDR && quiet
    |=> ptr_reg[7:0] == $past(shift_reg))
    else $error("word address not loaded");
  a_mack_advance: assert property (
    state_reg == i2cr_pkg::ST_MACK && scl_rise && !sda_s && quiet
    |=> ptr_reg == $past(ptr_reg) + 11'h1)
    else $error("master ack did not advance pointer");
  a_srst_self_clear: assert property (
    srst_reg && ce |=> !srst_reg && code_reg == i2cr_pkg::CODE_RST)
    else $error("serial reset did not clear or reload");
  a_read_locked: assert property (
    load_tx && !rd_ok |=> tx_reg == i2cr_pkg::LOCKED_RD_BYTE)
    else $error("protected byte leaked on read");
  a_hold_till_end: assert property (
    out_hold && quiet |=> out_hold)
    else $error("output hold dropped mid write");
endmodule

// File: verification/i2cr_master.sv
`timescale 1ns/100ps
module i2cr_master (
  input  wire logic core_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // scl stands high between frames; sda has a pull-up, so release reads 1
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // data moves only while scl is low, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    sda_low <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sda_line;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask
  // also a repeated start when entered with scl low
  task automatic start();
    sda_low <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(2);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(2);
    sda_low <= 1'b0;
    tick(6);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~mack, r);
  endtask
endmodule

// File: verification/tb_i2cr_cfg_slave.sv
`timescale 1ns/100ps
module tb_i2cr_cfg_slave;
  logic        core_clk;
  logic        rst;
  logic        ce;
  logic        scl;
  logic        sda_low;
  logic        sda_line;
  logic        sda_out;
  logic        sda_oe;
  logic [3:0]  pins;
  logic [63:0] macro_out;
  logic        out_hold;
  logic        por_restart;
  logic [3:0]  ctrl_code;
  logic        busy;
  logic [7:0]  mem_m [0:2047];
  int          num_errors;
  int          n_compared;
  int          por_seen;

  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));

  i2cr_cfg_slave i2cr_cfg_slave_i (
    .core_clk(core_clk), .rst(rst), .ce(ce),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_pin_bit0(pins[0]), .addr_pin_bit1(pins[1]),
    .addr_pin_bit2(pins[2]), .addr_pin_bit3(pins[3]),
    .macro_out(macro_out), .out_hold(out_hold),
    .por_restart(por_restart), .ctrl_code(ctrl_code), .busy(busy));
  i2cr_master i2cr_master_i (.core_clk(core_clk), .sda_line(sda_line),
    .scl(scl), .sda_low(sda_low));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (por_restart === 1'b1) por_seen++;

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e, string m);
    n_compared++;
    if ($isunknown(g) || g !== e) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    chk8({7'h0, g}, {7'h0, e}, m);
  endtask
  function automatic logic [3:0] exp_code();
    logic [7:0] c;
    c = mem_m[i2cr_pkg::ADDR_CODE];
    return (c[7:4] & pins) | (~c[7:4] & c[3:0]);
  endfunction
  function automatic logic [7:0] exp_rd(input logic [10:0] a);
    logic [1:0] p;
    p = mem_m[i2cr_pkg::ADDR_PROT][1:0];
    if (p[1] || (p == 2'h1 && a[10:8] == 3'h0)) return 8'h00;
    if (a[10:8] == 3'h0 && a[7:0] >= i2cr_pkg::MACRO_LO
        && a[7:0] <= i2cr_pkg::MACRO_HI)
      return macro_out[8 * int'(a[7:0] - i2cr_pkg::MACRO_LO) +: 8];
    return mem_m[a];
  endfunction
  task automatic model_wr(input logic [10:0] a, input logic [7:0] d);
    logic [1:0] p;
    logic       lk;
    p = mem_m[i2cr_pkg::ADDR_PROT][3:2];
    lk = p[1] || (p == 2'h1 && a[10:8] == 3'h0);
    if (a[10:8] == 3'h0 && a[7:0] >= i2cr_pkg::MACRO_LO
        && a[7:0] <= i2cr_pkg::MACRO_HI) lk = 1'b1;
    if (a == i2cr_pkg::ADDR_PROT || !lk) mem_m[a] = d;
    if (a == i2cr_pkg::ADDR_CTL && mem_m[a][1]) begin
      mem_m[i2cr_pkg::ADDR_CTL] = i2cr_pkg::CTL_RST;
      mem_m[i2cr_pkg::ADDR_CODE] = i2cr_pkg::CODE_RST;
      mem_m[i2cr_pkg::ADDR_PROT] = i2cr_pkg::PROT_RST;
    end
  endtask
  task automatic send(input logic [7:0] d, input logic ok, input string m);
    logic a;
    i2cr_master_i.wr_byte(d, a);
    chk1(a, ~ok, m);
  endtask
  task automatic wr_cmd(input logic [3:0] c, input logic [10:0] a,
                        input logic [7:0] dq [$]);
    logic hit;
    logic hold;
    hit = (c === exp_code());
    hold = mem_m[i2cr_pkg::ADDR_CTL][i2cr_pkg::CTL_LATCH_BIT]
           && a[10:8] == 3'h0;
    i2cr_master_i.start();
    send({c, a[10:8], 1'b0}, hit, "ctrl ack");
    send(a[7:0], hit, "addr ack");
    if (hit) chk1(out_hold, hold, "hold");
    chk1(busy, 1'b1, "busy");
    foreach (dq[i]) begin
      send(dq[i], hit, "data ack");
      if (hit) model_wr(a + 11'(i), dq[i]);
    end
    i2cr_master_i.stop();
    chk1(out_hold, 1'b0, "hold end");
    chk1(busy, 1'b0, "idle");
  endtask
  task automatic rd_cmd(input logic [10:0] a, input int n);
    logic [7:0] d;
    i2cr_master_i.start();
    send({exp_code(), a[10:8], 1'b0}, 1'b1, "ctrl ack");
    send(a[7:0], 1'b1, "addr ack");
    i2cr_master_i.start();
    send({exp_code(), a[10:8], 1'b1}, 1'b1, "rd ctrl ack");
    for (int i = 0; i < n; i++) begin
      i2cr_master_i.rd_byte(i < n - 1, d);
      chk8(d, exp_rd(a + 11'(i)), "rd data");
    end
    i2cr_master_i.stop();
  endtask
  task automatic cur_rd(input logic [10:0] a);
    logic [7:0] d;
    i2cr_master_i.start();
    send({exp_code(), 3'h0, 1'b1}, 1'b1, "cur ctrl ack");
    i2cr_master_i.rd_byte(1'b0, d);
    chk8(d, exp_rd(a), "cur data");
    i2cr_master_i.stop();
  endtask

  initial begin
    // roughly twice the cycles the full test list needs
    repeat (40000) @(posedge core_clk);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    logic [10:0] a;
    logic [10:0] b;
    logic [7:0]  dq [$];
    logic [7:0]  pv [5] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h00};
    rst = 1'b1;
    ce = 1'b1;
    macro_out = '0;
    num_errors = 0;
    n_compared = 0;
    por_seen = 0;
    void'($urandom(72));
    pins = 4'(1 + $urandom % 14);
    mem_m[i2cr_pkg::ADDR_CTL] = i2cr_pkg::CTL_RST;
    mem_m[i2cr_pkg::ADDR_CODE] = i2cr_pkg::CODE_RST;
    mem_m[i2cr_pkg::ADDR_PROT] = i2cr_pkg::PROT_RST;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk8({4'h0, ctrl_code}, 8'h01, "reset code");
    for (int t = 0; t < 6; t++) begin
      a = {3'(1 + $urandom % 7), 8'($urandom % 8'hF0)};
      wr_cmd(exp_code(), a, {8'($urandom)});
      rd_cmd(a, 1);
      wr_cmd(exp_code() ^ 4'h8, a, {8'($urandom)});
      rd_cmd(a, 1);
    end
    $display("byte write and random read done");
    a = {3'h2, 8'($urandom % 8'hF0)};
    dq = {};
    repeat (5) dq.push_back(8'($urandom));
    wr_cmd(exp_code(), a, dq);
    rd_cmd(a, 4);
    repeat (2) cur_rd(a + 11'h4);
    $display("sequential access done");
    macro_out <= {$urandom, $urandom};
    wr_cmd(exp_code(), {3'h0, i2cr_pkg::MACRO_LO}, {8'h5A});
    rd_cmd({3'h0, i2cr_pkg::MACRO_LO}, 8);
    $display("macro read done");
    for (int k = 0; k < 5; k++) begin
      wr_cmd(exp_code(), i2cr_pkg::ADDR_CODE,
             {k < 4 ? {4'(1 << k), 4'h1} : 8'h01});
      chk8({4'h0, ctrl_code}, {4'h0, exp_code()}, "code mix");
      if (k == 0) begin
        // pin bit 0 feeds the code now; a frozen block must not see it move
        ce <= 1'b0;
        pins[0] <= ~pins[0];
        repeat (6) @(posedge core_clk);
        chk8({4'h0, ctrl_code}, {7'h0, ~pins[0]}, "frozen code");
        ce <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk8({4'h0, ctrl_code}, {4'h0, exp_code()}, "thawed code");
      end
    end
    $display("code source done");
    b = {3'h3, 8'($urandom % 8'hF0)};
    wr_cmd(exp_code(), i2cr_pkg::ADDR_CTL, {8'h04});
    wr_cmd(exp_code(), 11'h020, {8'($urandom), 8'($urandom)});
    wr_cmd(exp_code(), b, {8'($urandom)});
    foreach (pv[i]) begin
      wr_cmd(exp_code(), i2cr_pkg::ADDR_PROT, {pv[i]});
      wr_cmd(exp_code(), 11'h020, {8'($urandom)});
      wr_cmd(exp_code(), b, {8'($urandom)});
      rd_cmd(11'h020, 1);
      rd_cmd(b, 1);
    end
    $display("latch and protection done");
    wr_cmd(exp_code(), i2cr_pkg::ADDR_CODE, {8'h03});
    wr_cmd(exp_code(), i2cr_pkg::ADDR_CTL, {8'h02});
    chk8(8'(por_seen), 8'h01, "restart pulse");
    chk8({4'h0, ctrl_code}, 8'h01, "code after restart");
    rd_cmd(i2cr_pkg::ADDR_CTL, 1);
    $display("serial reset done");
    conclude();
  end
endmodule
